// file: core/hbc_pkg.sv
// Package: constants and types for the dual H-bridge control and protection block
package hbc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OCP_QUAL_NS = 3000;
  localparam int unsigned OCP_QUAL_CYC = (OCP_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RETRY_US = 1000;
  localparam int unsigned RETRY_CYC = RETRY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 16;
  // Register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Interrupt status bits
  localparam int unsigned IRQ_OCP0 = 0;
  localparam int unsigned IRQ_OCP1 = 1;
  localparam int unsigned IRQ_TSD = 2;
  localparam int unsigned IRQ_UNDERVOLTAGE_LOCKOUT = 3;
  // Output drive code per pin
  typedef enum logic [1:0] {
    HBC_HIZ,
    HBC_LOW,
    HBC_HIGH
  } hbc_drive_t;
  typedef enum logic [1:0] {
    HBC_RUN,
    HBC_QUAL,
    HBC_RETRY
  } hbc_ocp_state_t;
endpackage : hbc_pkg

// file: core/hbc_top.sv
// Dual H-bridge decode, protection supervisor and APB status/interrupt registers
//
// Overview of operation
// - Mode pin low or floating selects direct inputs; high selects direction plus enable.
// - Direct mode: 00 coast, 01 a low b high, 10 a high b low, 11 brake.
// - Enable low brakes both low; enable high, direction 1 reverse, 0 forward.
// - Undriven control inputs read low through weak pull-downs.
// - Current limit held past qualification time disables all four bridge transistors.
// - High-side or low-side overcurrent both trigger the bridge shutdown.
// - Overcurrent-disabled bridge re-enables by itself after about 1 ms.
// - Over-temperature indication disables all bridge transistors.
// - Outputs resume on their own once over-temperature clears.
// - Undervoltage disables all outputs and returns the overcurrent supervisors to reset state.
// - Operation resumes when supply returns above the lockout threshold.
// - Supply removed enters low-power sleep, non-essential circuits off.
module hbc_top
  import hbc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins (pads already resolved, pull-down gives low when undriven)
  input wire logic mode_select,
  input wire logic [1:0] bridge_input_a,
  input wire logic [1:0] bridge_input_b,
  // Analog fault flags, per bridge high-side and low-side limit
  input wire logic [1:0] hs_current_limit,
  input wire logic [1:0] ls_current_limit,
  input wire logic over_temp,
  input wire logic logic_supply_low,
  input wire logic logic_supply_off,
  // Bridge outputs: value and enable (enable low means driven)
  output logic [1:0] bridge_output_a,
  output logic [1:0] bridge_output_a_oe_n,
  output logic [1:0] bridge_output_b,
  output logic [1:0] bridge_output_b_oe_n,
  output logic sleep_active,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage input synchronisers; a change counts when stages 2 and 3 agree
  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [NSYNC-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;

  assign raw = {logic_supply_off, logic_supply_low, over_temp, ls_current_limit,
                hs_current_limit, bridge_input_b[1], bridge_input_a[1], mode_select};

  always_comb begin
    s1_nxt = raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    filt_nxt = filt_r;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        filt_nxt[i] = s2_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      filt_r <= filt_nxt;
    end
  end

  // Second synchroniser bank for the remaining bridge inputs
  logic [3:0] in_raw, i1_r, i2_r, i3_r, ifl_r, i1_nxt, i2_nxt, i3_nxt, ifl_nxt;
  assign in_raw = {bridge_input_b[0], bridge_input_a[0], 2'b00};
  always_comb begin
    i1_nxt = in_raw;
    i2_nxt = i1_r;
    i3_nxt = i2_r;
    ifl_nxt = ifl_r;
    for (int i = 0; i < 4; i++) begin
      if (i2_r[i] == i3_r[i]) begin
        ifl_nxt[i] = i2_r[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i1_r <= '0;
      i2_r <= '0;
      i3_r <= '0;
      ifl_r <= '0;
    end else begin
      i1_r <= i1_nxt;
      i2_r <= i2_nxt;
      i3_r <= i3_nxt;
      ifl_r <= ifl_nxt;
    end
  end

  logic mode_q;
  logic [1:0] in_a_q, in_b_q, hs_q, ls_q;
  logic tsd_q, uv_q, off_q, lockout;
  assign mode_q = filt_r[0];
  assign in_a_q = {filt_r[1], ifl_r[2]};
  assign in_b_q = {filt_r[2], ifl_r[3]};
  assign hs_q = filt_r[4:3];
  assign ls_q = filt_r[6:5];
  assign tsd_q = filt_r[7];
  assign uv_q = filt_r[8];
  assign off_q = filt_r[9];
  assign lockout = uv_q | off_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode
  function automatic logic [3:0] decode(input logic mode, input logic ia, input logic ib);
    hbc_drive_t da, db;
    da = HBC_HIZ;
    db = HBC_HIZ;
    if (!mode) begin
      case ({ia, ib})
        2'b00: begin da = HBC_HIZ; db = HBC_HIZ; end
        2'b01: begin da = HBC_LOW; db = HBC_HIGH; end
        2'b10: begin da = HBC_HIGH; db = HBC_LOW; end
        default: begin da = HBC_LOW; db = HBC_LOW; end
      endcase
    end else if (!ia) begin
      da = HBC_LOW;
      db = HBC_LOW;
    end else if (ib) begin
      da = HBC_LOW;
      db = HBC_HIGH;
    end else begin
      da = HBC_HIGH;
      db = HBC_LOW;
    end
    return {da, db};
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // Per-bridge overcurrent supervisor
  hbc_ocp_state_t ocp_st_r [2];
  hbc_ocp_state_t ocp_st_nxt [2];
  logic [CNT_W-1:0] ocp_cnt_r [2];
  logic [CNT_W-1:0] ocp_cnt_nxt [2];
  logic [1:0] ocp_trip;
  logic [1:0] ocp_off;

  for (genvar b = 0; b < 2; b++) begin : g_ocp
    logic limit;
    assign limit = hs_q[b] | ls_q[b];
    always_comb begin
      ocp_st_nxt[b] = ocp_st_r[b];
      ocp_cnt_nxt[b] = ocp_cnt_r[b];
      ocp_trip[b] = 1'b0;
      case (ocp_st_r[b])
        HBC_RUN: begin
          ocp_cnt_nxt[b] = '0;
          if (limit) begin
            ocp_st_nxt[b] = HBC_QUAL;
          end
        end
        HBC_QUAL: begin
          if (!limit) begin
            ocp_st_nxt[b] = HBC_RUN;
            ocp_cnt_nxt[b] = '0;
          end else if (ocp_cnt_r[b] >= CNT_W'(OCP_QUAL_CYC - 1)) begin
            ocp_st_nxt[b] = HBC_RETRY;
            ocp_cnt_nxt[b] = '0;
            ocp_trip[b] = 1'b1;
          end else begin
            ocp_cnt_nxt[b] = ocp_cnt_r[b] + CNT_W'(1);
          end
        end
        HBC_RETRY: begin
          if (ocp_cnt_r[b] >= CNT_W'(RETRY_CYC - 1)) begin
            ocp_st_nxt[b] = HBC_RUN;
            ocp_cnt_nxt[b] = '0;
          end else begin
            ocp_cnt_nxt[b] = ocp_cnt_r[b] + CNT_W'(1);
          end
        end
        default: begin
          ocp_st_nxt[b] = HBC_RUN;
          ocp_cnt_nxt[b] = '0;
        end
      endcase
      if (lockout) begin
        ocp_st_nxt[b] = HBC_RUN;
        ocp_cnt_nxt[b] = '0;
        ocp_trip[b] = 1'b0;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ocp_st_r[b] <= HBC_RUN;
        ocp_cnt_r[b] <= '0;
      end else begin
        ocp_st_r[b] <= ocp_st_nxt[b];
        ocp_cnt_r[b] <= ocp_cnt_nxt[b];
      end
    end
    assign ocp_off[b] = (ocp_st_r[b] == HBC_RETRY);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive registers
  logic [1:0] oa_r, ob_r, oa_oen_r, ob_oen_r, oa_nxt, ob_nxt, oa_oen_nxt, ob_oen_nxt;
  logic [1:0] soft_dis;
  logic [31:0] ctrl_r, ctrl_nxt;
  assign soft_dis = ctrl_r[1:0];

  always_comb begin
    logic [3:0] d;
    d = '0;
    for (int b = 0; b < 2; b++) begin
      d = decode(mode_q, in_a_q[b], in_b_q[b]);
      oa_nxt[b] = (hbc_drive_t'(d[3:2]) == HBC_HIGH);
      ob_nxt[b] = (hbc_drive_t'(d[1:0]) == HBC_HIGH);
      oa_oen_nxt[b] = (hbc_drive_t'(d[3:2]) == HBC_HIZ);
      ob_oen_nxt[b] = (hbc_drive_t'(d[1:0]) == HBC_HIZ);
      if (ocp_off[b] || tsd_q || lockout || soft_dis[b]) begin
        oa_nxt[b] = 1'b0;
        ob_nxt[b] = 1'b0;
        oa_oen_nxt[b] = 1'b1;
        ob_oen_nxt[b] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oa_r <= '0;
      ob_r <= '0;
      oa_oen_r <= '1;
      ob_oen_r <= '1;
    end else begin
      oa_r <= oa_nxt;
      ob_r <= ob_nxt;
      oa_oen_r <= oa_oen_nxt;
      ob_oen_r <= ob_oen_nxt;
    end
  end

  assign bridge_output_a = oa_r;
  assign bridge_output_b = ob_r;
  assign bridge_output_a_oe_n = oa_oen_r;
  assign bridge_output_b_oe_n = ob_oen_r;
  assign sleep_active = off_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB registers and interrupt
  logic [3:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic tsd_d_r, uv_d_r, tsd_d_nxt, uv_d_nxt;
  logic wr, rd;
  logic [3:0] ev;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign ev = {uv_q & ~uv_d_r, tsd_q & ~tsd_d_r, ocp_trip};

  always_comb begin
    ctrl_nxt = ctrl_r;
    imask_nxt = imask_r;
    ist_nxt = ist_r;
    rdata_nxt = rdata_r;
    tsd_d_nxt = tsd_q;
    uv_d_nxt = uv_q;
    if (wr && paddr == ADDR_CTRL) begin
      ctrl_nxt = {30'h0000_0000, pwdata[1:0]};
    end
    if (wr && paddr == ADDR_IRQ_MASK) begin
      imask_nxt = pwdata[3:0];
    end
    if (wr && paddr == ADDR_IRQ_STAT) begin
      ist_nxt = ist_r & ~pwdata[3:0];
    end
    ist_nxt = ist_nxt | ev;
    if (rd) begin
      case (paddr)
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_STATUS: rdata_nxt = {23'h000000, off_q, uv_q, tsd_q, ocp_off, mode_q,
                                  2'b00, 1'b0};
        ADDR_IRQ_STAT: rdata_nxt = {28'h0000000, ist_r};
        ADDR_IRQ_MASK: rdata_nxt = {28'h0000000, imask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      imask_r <= MASK_RST;
      ist_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      tsd_d_r <= 1'b0;
      uv_d_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      imask_r <= imask_nxt;
      ist_r <= ist_nxt;
      rdata_r <= rdata_nxt;
      tsd_d_r <= tsd_d_nxt;
      uv_d_r <= uv_d_nxt;
    end
  end

  assign prdata = rdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != ADDR_CTRL) & (paddr != ADDR_STATUS) &
                   (paddr != ADDR_IRQ_STAT) & (paddr != ADDR_IRQ_MASK);
  assign irq = |(ist_r & imask_r);

endmodule : hbc_top

// file: bench/hbc_properties.sv
// Checker: bridge decode and protection properties at the block's pins
module hbc_properties (
  // Clock, reset and pins
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mode_select,
  input wire logic [1:0] bridge_input_a,
  input wire logic [1:0] bridge_input_b,
  input wire logic over_temp,
  input wire logic logic_supply_low,
  input wire logic logic_supply_off,
  input wire logic [1:0] bridge_output_a,
  input wire logic [1:0] bridge_output_a_oe_n,
  input wire logic [1:0] bridge_output_b,
  input wire logic [1:0] bridge_output_b_oe_n,
  input wire logic sleep_active
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [3:0] br0 = {bridge_output_a_oe_n[0], bridge_output_a[0], bridge_output_b_oe_n[0],
    bridge_output_b[0]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bridge 0 pins held long enough to pass the input synchronisers
  sequence s_in(logic m, logic [1:0] ab);
    (mode_select == m && {bridge_input_a[0], bridge_input_b[0]} == ab) [*8];
  endsequence
  sequence s_hiz;
    &{bridge_output_a_oe_n, bridge_output_b_oe_n};
  endsequence
  a_coast_hiz: assert property (s_in(1'b0, 2'b00) |-> br0 == 4'hA)
    else $error("coast wrong");
  a_fwd_drive: assert property (s_in(1'b0, 2'b10) |-> br0 inside {4'h4, 4'hA})
    else $error("forward wrong");
  a_brake_low: assert property (s_in(1'b0, 2'b11) |-> br0 inside {4'h0, 4'hA})
    else $error("brake wrong");
  a_rev_drive: assert property (s_in(1'b1, 2'b11) |-> br0 inside {4'h1, 4'hA})
    else $error("reverse wrong");
  a_en_low: assert property ((mode_select && !bridge_input_a[0]) [*8] |->
    br0 inside {4'h0, 4'hA})
    else $error("enable low wrong");
  a_temp_off: assert property (over_temp [*8] |-> s_hiz)
    else $error("hot bridge driven");
  a_uv_off: assert property (logic_supply_low [*8] |-> s_hiz)
    else $error("lockout bridge driven");
  a_sleep_flag: assert property (logic_supply_off [*8] |-> sleep_active ##0 s_hiz)
    else $error("sleep wrong");
endmodule : hbc_properties
bind hbc_top hbc_properties u_props (.*);

// file: bench/hbc_ctrl_model.sv
// Controller model: drives the mode select and bridge input pins
module hbc_ctrl_model (
  // Clock and control pins
  input wire logic pclk,
  output logic mode_select = 1'b0,
  output logic [1:0] in_a = 2'h0,
  output logic [1:0] in_b = 2'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic drive(input logic m, input logic [1:0] a, input logic [1:0] b);
    @(posedge pclk);
    {mode_select, in_a, in_b} <= {m, a, b};
  endtask : drive
  task automatic rest();
    drive(1'b0, 2'h0, 2'h0);
  endtask : rest
endmodule : hbc_ctrl_model

// file: bench/dual_hbridge_control_protect_tb.sv
// Testbench: pin decode, protection, interrupt and register checks
module dual_hbridge_control_protect_tb;
  import hbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mode_select, over_temp, irq;
  logic logic_supply_low, logic_supply_off, sleep_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [1:0] bridge_input_a, bridge_input_b, hs_current_limit, ls_current_limit;
  logic [1:0] bridge_output_a, bridge_output_a_oe_n, bridge_output_b, bridge_output_b_oe_n;
  int n_fail = 0, num_checks = 0, seed = 32'h1aa9d844;
  logic [32:0] rd_q[$];
  logic [9:0] pin_q[$];
  event pin_ev;
  wire [9:0] pins = {sleep_active, irq, bridge_output_a_oe_n[1], bridge_output_a[1],
    bridge_output_b_oe_n[1], bridge_output_b[1], bridge_output_a_oe_n[0], bridge_output_a[0],
    bridge_output_b_oe_n[0], bridge_output_b[0]};
  hbc_top DUT (.*);
  hbc_ctrl_model M (.pclk(pclk), .mode_select(mode_select), .in_a(bridge_input_a),
    .in_b(bridge_input_b));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic cmp(input logic [32:0] got, input logic [32:0] want);
    num_checks++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : cmp
  always @(posedge pclk)
    if (psel && penable && !pwrite && rd_q.size() > 0) cmp({pslverr, prdata}, rd_q.pop_front());
  always @(pin_ev) cmp(33'(pins), 33'(pin_q.pop_front()));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back({a > ADDR_IRQ_MASK, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic expect_pins(input logic [9:0] e);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    pin_q.push_back(e);
    -> pin_ev;
  endtask : expect_pins
  task automatic fl(input logic [6:0] f);
    @(posedge pclk);
    {logic_supply_off, logic_supply_low, over_temp, ls_current_limit, hs_current_limit} <= f;
  endtask : fl
  function automatic logic [3:0] dec(input logic m, input logic x, input logic y);
    return m ? (x ? (y ? 4'h1 : 4'h4) : 4'h0) : (x ? (y ? 4'h0 : 4'h4) : (y ? 4'h1 : 4'hA));
  endfunction : dec
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (80000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hs_current_limit, ls_current_limit} = '0;
    {over_temp, logic_supply_low, logic_supply_off} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_IRQ_MASK, 32'(MASK_RST));
    rd(12'h010, 32'h0);
    for (int i = 0; i < 48; i++) begin
      v = (i < 32) ? 32'(i) : $random(seed);
      M.drive(v[4], v[1:0], v[3:2]);
      expect_pins({2'h0, dec(v[4], v[1], v[3]), dec(v[4], v[0], v[2])});
    end
    // Both bridges forward before the protection scenarios
    M.drive(1'b0, 2'h3, 2'h0);
    expect_pins(10'h044);
    apb(1'b1, ADDR_CTRL, 32'h3);
    expect_pins(10'h0AA);
    rd(ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'hF);
    fl(7'h10);
    expect_pins(10'h1AA);
    fl(7'h00);
    expect_pins(10'h144);
    rd(ADDR_IRQ_STAT, 32'h4);
    apb(1'b1, ADDR_IRQ_STAT, 32'h4);
    fl(7'h09);
    repeat (200) @(posedge pclk);
    fl(7'h00);
    expect_pins(10'h1AA);
    rd(ADDR_IRQ_STAT, 32'h3);
    repeat (49500) @(posedge pclk);
    expect_pins(10'h1AA);
    repeat (600) @(posedge pclk);
    expect_pins(10'h144);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    fl(7'h20);
    expect_pins(10'h0AA);
    fl(7'h00);
    expect_pins(10'h044);
    fl(7'h40);
    M.rest();
    expect_pins(10'h2AA);
    rd(ADDR_STATUS, 32'h100);
    print_verdict();
  end
endmodule : dual_hbridge_control_protect_tb
